// [sent_fault_defs.svh]
// constants for the SENT fault reporting and reset sequencing block
// Function
// - init message sent once after each reset
// - switch to measured values once available
// - hard reset request executed immediately
// - soft reset after 400 ms, persisting, reported
// - before 400 ms keep repeating diagnostic message
// - flag under/overvoltage, persistent and transient
// - error code replaces fast-channel data on fault; under/overvoltage keeps measured values
// - OTP unset: 4095 everywhere, both bits, code 0
// - sensing element fault gives fast value 4091
// - signal processing fault gives fast value 4090
// - degraded accuracy gives fast value 4089
// - init phase: fast 0, code 0, bit clear
// - RAM/ROM fail: 2070, 4090 everywhere, reset
// - status bits and diagnostic carry fault detail
// - diagnostic message id 01 recurs periodically
// - undervoltage: code 32, 4089, measured value wins
`ifndef SENT_FAULT_DEFS_SVH
`define SENT_FAULT_DEFS_SVH

`define CLK_MHZ             200
`define SOFT_RESET_DELAY_MS 400
`define FRAME_PERIOD_US     1000
`define DIAG_MSG_ID         8'h01

`define FC_OTP_UNSET        12'hFFF
`define FC_SENSOR_FAULT     12'hFFB
`define FC_PROC_FAULT       12'hFFA
`define FC_DEGRADED         12'hFF9
`define FC_INIT             12'h000
`define FC_MEAS_MAX         12'hFF8

`define SLOW_CODE_NONE      12'h000
`define SLOW_CODE_MEM_FAIL  12'h816
`define SLOW_CODE_SENSOR    12'h810
`define SLOW_CODE_PROC      12'h003
`define SLOW_CODE_DEGRADED  12'h81C
`define SLOW_CODE_UNDERVOLT 12'h020
`define SLOW_CODE_OVERVOLT  12'h021

`define UV_THRESHOLD_DEF    12'h400
`define OV_THRESHOLD_DEF    12'hC00

`endif

// [sent_fault_pkg.sv]
// types shared by the SENT fault reporting block
package sent_fault_pkg;

    typedef enum logic [1:0] {
        S_INIT_FIRST,
        S_INIT_WAIT,
        S_RUN
    } seq_state_t;

    typedef struct packed {
        logic [11:0] fc1;
        logic [11:0] fc2;
        logic        st_err1;
        logic        st_err2;
        logic [11:0] supp_temp;
        logic [11:0] supp_volt;
        logic [11:0] slow_code;
        logic        diag_repeat;
        logic        is_init;
    } sent_frame_t;

endpackage

// [sent_frame_buf.sv]
// two-entry frame buffer, head entry drives the output directly
`timescale 1ns/1ps
module sent_frame_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    generate
        if (DEPTH != 2 || WIDTH < 1)
        begin : g_bad
            $error("sent_frame_buf serves only two entries");
        end
    endgenerate

    logic [1:0]       count;
    logic [WIDTH-1:0] second;
    logic             push;
    logic             pop;

    assign in_ready_o = (count != 2'h2);
    assign push       = in_valid_i && in_ready_o;
    assign pop        = out_valid_o && out_ready_i;

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            count <= 2'h0;
        else
            count <= count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            out_valid_o <= 1'b0;
        else
            out_valid_o <= (count + {1'b0, push} - {1'b0, pop}) != 2'h0;
    end

    // head refills from the second slot on pop, so the receiver never sees a gap
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            out_data_o <= '0;
            second     <= '0;
        end
        else
        begin
            if (pop && count == 2'h2)
                out_data_o <= second;
            else if (push && (count == 2'h0 || (pop && count == 2'h1)))
                out_data_o <= in_data_i;
            if (push && (count == 2'h2 || (count == 2'h1 && !pop)))
                second <= in_data_i;
            else if (push && pop && count == 2'h2)
                second <= in_data_i;
        end
    end
endmodule

// [sent_fault_reporting.sv]
// fault coding, init message and reset sequencing ahead of the SENT framer
`timescale 1ns/1ps
`include "sent_fault_defs.svh"
module sent_fault_reporting
    import sent_fault_pkg::*;
#(
    parameter int          SOFT_HOLD_CYCLES = `SOFT_RESET_DELAY_MS * `CLK_MHZ * 1000,
    parameter int          FRAME_CYCLES     = `FRAME_PERIOD_US * `CLK_MHZ,
    parameter logic [11:0] UV_THRESHOLD     = `UV_THRESHOLD_DEF,
    parameter logic [11:0] OV_THRESHOLD     = `OV_THRESHOLD_DEF
) (
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic        meas_valid_i,
    input  wire logic [11:0] pressure_i,
    input  wire logic [11:0] temperature_i,
    input  wire logic [11:0] ref_temp_i,
    input  wire logic        supply_valid_i,
    input  wire logic [11:0] supply_level_i,
    input  wire logic        otp_unset_i,
    input  wire logic        mem_check_fail_i,
    input  wire logic        sensor_fault_i,
    input  wire logic        proc_fault_i,
    input  wire logic        degraded_i,
    input  wire logic        hard_reset_req_i,
    input  wire logic        slow_diag_sent_i,
    input  wire logic [11:0] slow_diag_code_i,
    output sent_frame_t      frame_o,
    output logic             frame_valid_o,
    input  wire logic        frame_ready_i,
    output logic             core_reset_o,
    output logic             init_active_o
);
    localparam int UPW = $clog2(SOFT_HOLD_CYCLES + 1);
    localparam int FDW = $clog2(FRAME_CYCLES);

    generate
        if (SOFT_HOLD_CYCLES < 1 || FRAME_CYCLES < 2)
        begin : g_bad
            $error("hold-off and frame period must be positive");
        end
    endgenerate

    seq_state_t  state;
    sent_frame_t next_frame;
    logic [UPW-1:0] uptime;
    logic [FDW-1:0] frame_div;
    logic        uptime_done;
    logic        frame_tick;
    logic        push_pend;
    logic        buf_ready;
    logic        push_fire;
    logic        uv_now;
    logic        ov_now;
    logic        uv_seen;
    logic        ov_seen;
    logic        uv_flag;
    logic        ov_flag;
    logic        reset_fault;
    logic        diag_reported;
    logic        soft_go;
    logic        hard_go;

    assign uptime_done = (uptime == UPW'(SOFT_HOLD_CYCLES));
    assign push_fire   = push_pend && buf_ready;
    assign uv_now      = supply_valid_i && (supply_level_i < UV_THRESHOLD);
    assign ov_now      = supply_valid_i && (supply_level_i > OV_THRESHOLD);
    assign uv_flag     = uv_now || uv_seen;
    assign ov_flag     = ov_now || ov_seen;
    // faults whose reset flag is set; the production stage never takes a soft reset
    assign reset_fault = !otp_unset_i && (mem_check_fail_i || sensor_fault_i || proc_fault_i);
    assign soft_go     = reset_fault && uptime_done && diag_reported;
    assign hard_go     = hard_reset_req_i;

    // power-on reference: only reset_i restarts it, internal resets do not
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            uptime <= '0;
        else if (!uptime_done)
            uptime <= uptime + UPW'(1);
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            frame_div  <= '0;
            frame_tick <= 1'b0;
        end
        else
        begin
            frame_tick <= (frame_div == FDW'(FRAME_CYCLES - 1));
            if (frame_div == FDW'(FRAME_CYCLES - 1))
                frame_div <= '0;
            else
                frame_div <= frame_div + FDW'(1);
        end
    end

    // a tick that meets a full buffer waits instead of being dropped
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            push_pend <= 1'b0;
        else if (frame_tick)
            push_pend <= 1'b1;
        else if (push_fire)
            push_pend <= 1'b0;
    end

    // short excursions are held until the slow channel has carried them
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            uv_seen <= 1'b0;
            ov_seen <= 1'b0;
        end
        else
        begin
            if (uv_now)
                uv_seen <= 1'b1;
            else if (slow_diag_sent_i && slow_diag_code_i == `SLOW_CODE_UNDERVOLT)
                uv_seen <= 1'b0;
            if (ov_now)
                ov_seen <= 1'b1;
            else if (slow_diag_sent_i && slow_diag_code_i == `SLOW_CODE_OVERVOLT)
                ov_seen <= 1'b0;
        end
    end

    // cause counts as reported once the diagnostic went out with this code
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            diag_reported <= 1'b0;
        // a taken reset consumes the report, else the next cycle would reset again
        else if (hard_go || soft_go)
            diag_reported <= 1'b0;
        else if (reset_fault && slow_diag_sent_i && slow_diag_code_i == next_frame.slow_code)
            diag_reported <= 1'b1;
        else if (!reset_fault)
            diag_reported <= 1'b0;
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            core_reset_o <= 1'b0;
        else
            core_reset_o <= hard_go || soft_go;
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            state <= S_INIT_FIRST;
        else if (hard_go || soft_go)
            state <= S_INIT_FIRST;
        else
        begin
            unique case (state)
                S_INIT_FIRST:
                    if (push_fire)
                        state <= meas_valid_i ? S_RUN : S_INIT_WAIT;
                S_INIT_WAIT:
                    if (meas_valid_i)
                        state <= S_RUN;
                S_RUN:
                    state <= S_RUN;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            init_active_o <= 1'b1;
        else
            init_active_o <= (hard_go || soft_go) || (state != S_RUN && !(state == S_INIT_WAIT && meas_valid_i)
                             && !(state == S_INIT_FIRST && push_fire && meas_valid_i));
    end

    always_comb
    begin
        next_frame             = '0;
        // measured values stop below the error codes
        next_frame.fc1         = (pressure_i > `FC_MEAS_MAX) ? `FC_MEAS_MAX : pressure_i;
        next_frame.fc2         = (temperature_i > `FC_MEAS_MAX) ? `FC_MEAS_MAX : temperature_i;
        next_frame.supp_temp   = (ref_temp_i > `FC_MEAS_MAX) ? `FC_MEAS_MAX : ref_temp_i;
        next_frame.supp_volt   = (supply_level_i > `FC_MEAS_MAX) ? `FC_MEAS_MAX : supply_level_i;
        next_frame.slow_code   = `SLOW_CODE_NONE;
        next_frame.diag_repeat = reset_fault;
        if (state != S_RUN)
        begin
            next_frame.fc1     = `FC_INIT;
            next_frame.fc2     = `FC_INIT;
            next_frame.st_err1 = 1'b0;
            next_frame.is_init = (state == S_INIT_FIRST);
        end
        else if (otp_unset_i)
        begin
            next_frame.fc1       = `FC_OTP_UNSET;
            next_frame.fc2       = `FC_OTP_UNSET;
            next_frame.supp_temp = `FC_OTP_UNSET;
            next_frame.supp_volt = `FC_OTP_UNSET;
            next_frame.st_err1   = 1'b1;
            next_frame.st_err2   = 1'b1;
        end
        else if (mem_check_fail_i)
        begin
            next_frame.fc1       = `FC_PROC_FAULT;
            next_frame.fc2       = `FC_PROC_FAULT;
            next_frame.supp_temp = `FC_PROC_FAULT;
            next_frame.supp_volt = `FC_PROC_FAULT;
            next_frame.st_err1   = 1'b1;
            next_frame.st_err2   = 1'b1;
            next_frame.slow_code = `SLOW_CODE_MEM_FAIL;
        end
        else if (proc_fault_i)
        begin
            next_frame.fc1       = `FC_PROC_FAULT;
            next_frame.fc2       = `FC_PROC_FAULT;
            next_frame.supp_temp = `FC_PROC_FAULT;
            next_frame.supp_volt = `FC_PROC_FAULT;
            next_frame.st_err1   = 1'b1;
            next_frame.st_err2   = 1'b1;
            next_frame.slow_code = `SLOW_CODE_PROC;
        end
        else if (sensor_fault_i)
        begin
            next_frame.fc1       = `FC_SENSOR_FAULT;
            next_frame.st_err1   = 1'b1;
            next_frame.slow_code = `SLOW_CODE_SENSOR;
        end
        else if (degraded_i)
        begin
            next_frame.fc1       = `FC_DEGRADED;
            next_frame.st_err1   = 1'b1;
            next_frame.slow_code = `SLOW_CODE_DEGRADED;
        end
        else if (uv_flag || ov_flag)
        begin
            // measured value keeps the fast channels, only detail changes
            next_frame.supp_volt = `FC_DEGRADED;
            next_frame.st_err1   = 1'b1;
            next_frame.st_err2   = 1'b1;
            next_frame.slow_code = uv_flag ? `SLOW_CODE_UNDERVOLT : `SLOW_CODE_OVERVOLT;
        end
    end

    sent_frame_buf #(
        .WIDTH ($bits(sent_frame_t)),
        .DEPTH (2)
    ) u_buf (
        .core_clk_i  (core_clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (push_pend),
        .in_ready_o  (buf_ready),
        .in_data_i   (next_frame),
        .out_valid_o (frame_valid_o),
        .out_ready_i (frame_ready_i),
        .out_data_o  (frame_o)
    );

    sequence s_init_taken;
        push_fire && next_frame.is_init;
    endsequence

    sequence s_soft_ready;
        reset_fault && uptime_done && diag_reported;
    endsequence

    property p_init_once;
        @(posedge core_clk_i) disable iff (reset_i)
        s_init_taken and (!hard_go && !soft_go) |=> state != S_INIT_FIRST;
    endproperty
    a_init_once: assert property (p_init_once) else $error("init message may repeat");

    property p_to_run;
        @(posedge core_clk_i) disable iff (reset_i)
        state == S_INIT_WAIT && meas_valid_i && !hard_go && !soft_go |=> state == S_RUN;
    endproperty
    a_to_run: assert property (p_to_run) else $error("measured values not taken up");

    property p_hard_now;
        @(posedge core_clk_i) disable iff (reset_i)
        hard_reset_req_i |=> core_reset_o && state == S_INIT_FIRST;
    endproperty
    a_hard_now: assert property (p_hard_now) else $error("hard reset deferred");

    property p_soft_cause;
        @(posedge core_clk_i) disable iff (reset_i)
        core_reset_o && !$past(hard_reset_req_i) |-> $past(reset_fault) && $past(uptime_done) && $past(diag_reported);
    endproperty
    a_soft_cause: assert property (p_soft_cause) else $error("soft reset without cause");

    property p_soft_take;
        @(posedge core_clk_i) disable iff (reset_i)
        s_soft_ready |=> core_reset_o;
    endproperty
    a_soft_take: assert property (p_soft_take) else $error("soft reset not taken");

    property p_early_repeat;
        @(posedge core_clk_i) disable iff (reset_i)
        reset_fault && !uptime_done |-> next_frame.diag_repeat && !core_reset_o || $past(hard_reset_req_i);
    endproperty
    a_early_repeat: assert property (p_early_repeat) else $error("diagnostic not repeated early");

    property p_uv_caught;
        @(posedge core_clk_i) disable iff (reset_i)
        uv_now |=> uv_seen [*2] or (uv_seen ##1 !uv_seen);
    endproperty
    a_uv_caught: assert property (p_uv_caught) else $error("undervoltage excursion lost");

    property p_otp_code;
        @(posedge core_clk_i) disable iff (reset_i)
        state == S_RUN && otp_unset_i |-> next_frame.fc1 == `FC_OTP_UNSET && next_frame.fc2 == `FC_OTP_UNSET
            && next_frame.slow_code == `SLOW_CODE_NONE && next_frame.st_err2 && !reset_fault;
    endproperty
    a_otp_code: assert property (p_otp_code) else $error("production stage frame wrong");

    property p_mem_code;
        @(posedge core_clk_i) disable iff (reset_i)
        state == S_RUN && !otp_unset_i && mem_check_fail_i |-> next_frame.slow_code == `SLOW_CODE_MEM_FAIL
            && next_frame.fc2 == `FC_PROC_FAULT && next_frame.supp_volt == `FC_PROC_FAULT && reset_fault;
    endproperty
    a_mem_code: assert property (p_mem_code) else $error("memory check frame wrong");

    property p_init_frame;
        @(posedge core_clk_i) disable iff (reset_i)
        state != S_RUN |-> next_frame.fc1 == `FC_INIT && !next_frame.st_err1
            && next_frame.slow_code == `SLOW_CODE_NONE;
    endproperty
    a_init_frame: assert property (p_init_frame) else $error("init frame contents wrong");

    property p_no_unused;
        @(posedge core_clk_i) disable iff (reset_i)
        frame_valid_o |-> !(frame_o.fc1 > `FC_SENSOR_FAULT && frame_o.fc1 < `FC_OTP_UNSET)
            && !(frame_o.fc2 > `FC_SENSOR_FAULT && frame_o.fc2 < `FC_OTP_UNSET);
    endproperty
    a_no_unused: assert property (p_no_unused) else $error("unused fast code sent");

    property p_uv_keeps_value;
        @(posedge core_clk_i) disable iff (reset_i)
        state == S_RUN && uv_now && !otp_unset_i && !mem_check_fail_i && !proc_fault_i && !sensor_fault_i
            && !degraded_i && pressure_i < `FC_MEAS_MAX |-> next_frame.fc1 == pressure_i
            && next_frame.slow_code == `SLOW_CODE_UNDERVOLT;
    endproperty
    a_uv_keeps_value: assert property (p_uv_keeps_value) else $error("undervoltage frame wrong");
endmodule

// [sent_rx_model.sv]
// behavioural SENT framer and receiver facing the fault block
`timescale 1ns/1ps
module sent_rx_model
    import sent_fault_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic        stall_i,
    input  wire logic        frame_valid_i,
    input  wire sent_frame_t frame_i,
    output logic             frame_ready_o,
    output logic             diag_sent_o,
    output logic      [11:0] diag_code_o,
    output int               diag_frames_o
);
    int seed = 1;
    always @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            frame_ready_o <= 1'b0;
            diag_sent_o   <= 1'b0;
            diag_code_o   <= 12'h000;
            diag_frames_o <= 0;
        end
        else
        begin
            // random stalls, so the block never sees a kind receiver
            frame_ready_o <= !stall_i && (($random(seed) & 1) != 0);
            // every taken frame ends one diagnostic slot carrying its code
            diag_sent_o   <= frame_valid_i && frame_ready_o;
            // code is only meaningful with the pulse; otherwise it keeps changing
            diag_code_o   <= (frame_valid_i && frame_ready_o) ? frame_i.slow_code : ~diag_code_o;
            if (frame_valid_i && frame_ready_o && frame_i.fc1 >= 12'hFF9)
                diag_frames_o <= diag_frames_o + 1;
        end
    end
endmodule

// [test_sent_fault_reporting.sv]
// self-checking bench for the fault coding and reset sequencing block
`timescale 1ns/1ps
module test_sent_fault_reporting
    import sent_fault_pkg::*;
;
    localparam int HOLD = 2000;
    logic core_clk_i = 0, reset_i = 1, meas = 0, sup_ok = 1, otp = 0, mem = 0, prc = 0, sens = 0, degr = 0;
    logic hard = 0, stall = 0, frame_valid, ready, core_reset, init_active, diag_sent;
    logic [11:0] pr = 12'h123, tp = 12'h234, rtemp = 12'h345, lvl = 12'h800, diag_code;
    sent_frame_t frame, snap;
    sent_frame_t q_exp[$], q_msk[$];
    int fails = 0, compares = 0, seed = 1, cycles = 0, inits = 0, resets = 0, uv_seen = 0, diag_frames, n;

    sent_fault_reporting #(.SOFT_HOLD_CYCLES(HOLD), .FRAME_CYCLES(8)) u_dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .meas_valid_i(meas), .pressure_i(pr),
        .temperature_i(tp), .ref_temp_i(rtemp), .supply_valid_i(sup_ok), .supply_level_i(lvl),
        .otp_unset_i(otp), .mem_check_fail_i(mem), .sensor_fault_i(sens), .proc_fault_i(prc),
        .degraded_i(degr), .hard_reset_req_i(hard), .slow_diag_sent_i(diag_sent),
        .slow_diag_code_i(diag_code), .frame_o(frame), .frame_valid_o(frame_valid),
        .frame_ready_i(ready), .core_reset_o(core_reset), .init_active_o(init_active));
    sent_rx_model u_rx (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .stall_i(stall), .frame_valid_i(frame_valid),
        .frame_i(frame), .frame_ready_o(ready), .diag_sent_o(diag_sent), .diag_code_o(diag_code),
        .diag_frames_o(diag_frames));

    always #2.5 core_clk_i = ~core_clk_i;

    task automatic end_of_test();
        if (fails == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp_frame(sent_frame_t got, sent_frame_t exp, sent_frame_t msk);
        compares++;
        if ((got & msk) !== (exp & msk))
        begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got & msk, exp & msk);
        end
    endtask

    task automatic cmp_val(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    always @(posedge core_clk_i)
    begin
        cycles++;
        if (core_reset === 1'b1)
            resets++;
        if (frame_valid === 1'b1 && ready === 1'b1)
        begin
            if (frame.is_init === 1'b1)
                inits++;
            if (frame.slow_code === 12'h020)
                uv_seen++;
            cmp_val(frame.fc1 inside {[12'hFFC:12'hFFE]}, 0);
            if (q_exp.size() > 0)
                cmp_frame(frame, q_exp.pop_front(), q_msk.pop_front());
        end
    end

    always @(posedge core_clk_i)
    begin
        if (cycles >= 20000)
        begin
            fails++;
            end_of_test();
        end
    end

    task automatic expect_frame(sent_frame_t exp, sent_frame_t msk);
        int k;
        // let frames composed before the input change drain out of the buffer
        repeat (48) @(posedge core_clk_i);
        q_exp.push_back(exp);
        q_msk.push_back(msk);
        k = 0;
        while (q_exp.size() > 0 && k < 200)
        begin
            @(posedge core_clk_i);
            k++;
        end
        cmp_val(q_exp.size(), 0);
        #1;
    endtask

    // k: 0 core fields only, 1 no supplementary, 2 no supplementary temperature, 3 all
    task automatic fault_case(logic [4:0] f, logic [11:0] v, logic [11:0] f1, logic [11:0] f2, logic e1,
                              logic e2, logic [11:0] sv, logic [11:0] code, logic rep, int k);
        sent_frame_t e;
        sent_frame_t m;
        pr = 12'($unsigned($random(seed)) % 4089);
        tp = 12'($unsigned($random(seed)) % 4089);
        {otp, mem, prc, sens, degr} = f;
        lvl = v;
        e = '{fc1:f1, fc2:f2, st_err1:e1, st_err2:e2, supp_temp:sv, supp_volt:sv, slow_code:code,
              diag_repeat:rep, is_init:1'b0};
        if (f1 == 12'h001)
            e.fc1 = pr;
        if (f2 == 12'h001)
            e.fc2 = tp;
        m = '1;
        if (k < 3)
            m.supp_temp = '0;
        if (k < 2)
            m.supp_volt = '0;
        if (k < 1)
        begin
            m.fc2 = '0;
            m.st_err2 = '0;
        end
        expect_frame(e, m);
    endtask

    initial
    begin
        repeat (2) @(posedge core_clk_i);
        #1 reset_i = 0;
        fault_case(5'b00000, 12'h800, 12'h000, 12'h000, 0, 0, 0, 12'h000, 0, 0);
        cmp_val(init_active, 1);
        cmp_val(inits, 1);
        meas = 1;
        fault_case(5'b00000, 12'h800, 12'h001, 12'h001, 0, 0, 0, 12'h000, 0, 1);
        cmp_val(init_active, 0);
        stall = 1;
        repeat (12) @(posedge core_clk_i);
        #1 snap = frame;
        repeat (40) @(posedge core_clk_i);
        cmp_frame(frame, snap, '1);
        cmp_val(frame_valid, 1);
        #1 stall = 0;
        fault_case(5'b10000, 12'h800, 12'hFFF, 12'hFFF, 1, 1, 12'hFFF, 12'h000, 0, 3);
        fault_case(5'b11000, 12'h800, 12'hFFF, 12'hFFF, 1, 1, 12'hFFF, 12'h000, 0, 3);
        fault_case(5'b01000, 12'h800, 12'hFFA, 12'hFFA, 1, 1, 12'hFFA, 12'h816, 1, 3);
        fault_case(5'b00100, 12'h800, 12'hFFA, 12'hFFA, 1, 1, 12'hFFA, 12'h003, 1, 3);
        fault_case(5'b00010, 12'h800, 12'hFFB, 12'h000, 1, 0, 0, 12'h810, 1, 0);
        fault_case(5'b00011, 12'h800, 12'hFFB, 12'h000, 1, 0, 0, 12'h810, 1, 0);
        fault_case(5'b00001, 12'h800, 12'hFF9, 12'h000, 1, 0, 0, 12'h81C, 0, 0);
        fault_case(5'b00000, 12'h100, 12'h001, 12'h001, 1, 1, 12'hFF9, 12'h020, 0, 2);
        fault_case(5'b00000, 12'hF00, 12'h001, 12'h001, 1, 1, 12'hFF9, 12'h021, 0, 2);
        lvl = 12'h800;
        repeat (60) @(posedge core_clk_i);
        n = uv_seen;
        #1 lvl = 12'h0FF;
        @(posedge core_clk_i);
        #1 lvl = 12'h800;
        repeat (60) @(posedge core_clk_i);
        cmp_val(uv_seen > n, 1);
        cmp_val(resets, 0);
        cmp_val(diag_frames > 0, 1);
        while (cycles < HOLD + 50)
            @(posedge core_clk_i);
        #1 mem = 1;
        n = 0;
        while (core_reset !== 1'b1 && n < 300)
        begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        mem = 0;
        repeat (100) @(posedge core_clk_i);
        cmp_val(resets, 1);
        cmp_val(inits, 2);
        #1 hard = 1;
        @(posedge core_clk_i);
        #1 hard = 0;
        cmp_val(core_reset, 1);
        repeat (100) @(posedge core_clk_i);
        cmp_val(resets, 2);
        cmp_val(inits, 3);
        end_of_test();
    end
endmodule
